//--- rtl/smr_mode_regs.sv
// Mode register bank: device information, burst features, burst ordering
//
// Overview of operation
// - Bit 0 reports auto-initialisation in progress.
// - Bit 2 zero; bit 1 gives device kind.
// - Bits 4:3 hold calibration resistor self-test.
// - Self-test updates when write-started calibration completes.
// - Pin tied to CA supply reads 01.
// - Fault codes force factory trim, ignore calibration.
// - Code 11 means only resistor present.
// - Bits 2:0 select 4, 8, 16 beats.
// - Bit 3 burst type, bit 4 wrap.
// - Bits 7:5 give recovery cycles 3 to 8.
// - Wrap mode orders columns from start column.
// - No-wrap 4 beats counts up linearly.
// - Lowest column bit always treated as zero.
// - Read and write commands; reads answer data.
// - Reserved bits read back as zero.
// - Writes to read-only register change nothing.
`timescale 1ns/1ps
`default_nettype none
module smr_mode_regs
   import smr_pkg::*;
#(
   parameter int COL_W = 10, // Column address width
   parameter int AUTO_INIT_CYCLES = 200, // Self-initialisation length
   parameter int CALIB_CYCLES = 16, // Calibration length
   parameter bit SELFTEST_SUPPORTED = 1'b1, // Resistor self-test present
   parameter bit DEVICE_IS_NVM = 1'b0 // Device kind
) (
   input wire logic I_CLK,
   input wire logic I_SRST,
   input wire smr_cmd_t I_CMD,
   input wire logic [1:0] I_PIN_SENSE,
   input wire logic I_BURST_START,
   input wire logic [COL_W-1:0] I_BURST_COL,
   output logic O_RD_VALID,
   output logic [7:0] O_RD_DATA,
   output logic O_AUTO_INIT_BUSY,
   output logic O_USE_FACTORY_TRIM,
   output logic O_CALIB_BUSY,
   output logic [3:0] O_RECOVERY_CYCLES,
   output logic O_BURST_VALID,
   output logic [COL_W-1:0] O_BURST_COL,
   output logic O_BURST_LAST
);

   // Column of beat idx for a burst from start, by length mask and mode
   function automatic logic [COL_W-1:0] burst_col(
      input logic [COL_W-1:0] start, input logic [3:0] idx,
      input logic [3:0] mask, input logic intl, input logic nowrap);
      logic [COL_W-1:0] base;
      logic [3:0] low;
      base = {start[COL_W-1:1], 1'b0}; // Lowest bit implied zero
      low = intl ? (base[3:0] ^ idx) : (base[3:0] + idx);
      if (nowrap) begin
         burst_col = base + COL_W'(idx); // Linear, no wrap
      end else begin
         burst_col = {base[COL_W-1:4], (low & mask) | (base[3:0] & ~mask)};
      end
   endfunction

   // Beats for a length code; reserved codes act as 4 beats
   function automatic logic [4:0] beats_of(input logic [2:0] code);
      beats_of = (code == SMR_BL8) ? SMR_BEATS8 :
                 (code == SMR_BL16) ? SMR_BEATS16 : SMR_BEATS4;
   endfunction

   localparam int INIT_W = $clog2(AUTO_INIT_CYCLES + 1);
   localparam int CAL_W = $clog2(CALIB_CYCLES + 1);

   // Register state
   smr_feat_t feat; // burst_feature_config
   logic [1:0] selftest; // calib_resistor_selftest
   logic [INIT_W-1:0] init_cnt; // Cycles left of self-initialisation
   logic auto_init_flag; // 1 while self-initialisation runs
   smr_cstate_t cal_state; // Calibration sequencer
   logic [CAL_W-1:0] cal_cnt; // Cycles left of calibration

   // Burst engine state
   smr_bstate_t b_state;
   logic [4:0] beat; // Current beat index
   logic [4:0] beats; // Beats in this burst
   logic [COL_W-1:0] b_start; // Start column
   logic b_intl; // Interleaved order latched
   logic b_nowrap; // No-wrap latched
   logic [3:0] b_mask; // Low column bits that wrap

   // Command decode
   wire logic wr_feat; // Write to burst_feature_config
   wire logic wr_cal; // Accepted calibration command
   wire logic rd_info; // Read of device_info_status
   wire logic st_fault; // Self-test shows assembly fault
   wire logic cal_done; // Calibration finishes this cycle
   wire logic [1:0] st_result; // Self-test result from pin sense
   wire logic [7:0] info_word; // Assembled information register
   wire logic [7:0] rd_word; // Read data selection
   wire logic [4:0] next_beats; // Beats for a new burst
   wire logic [3:0] next_mask; // Wrap mask for a new burst
   wire logic burst_last; // Final beat of a running burst
   wire logic [3:0] wr_cycles; // Decoded recovery cycles

   // Feature and calibration registers are writable; info writes fall through
   assign wr_feat = I_CMD.mode_reg_write_cmd
                    && (I_CMD.addr == SMR_ADDR_FEAT);
   assign st_fault = (selftest == SMR_ST_CA_FLOAT)
                     || (selftest == SMR_ST_GND);
   assign wr_cal = I_CMD.mode_reg_write_cmd && (I_CMD.addr == SMR_ADDR_CAL)
                   && !st_fault && (cal_state == SMR_C_IDLE);
   assign rd_info = I_CMD.mode_reg_read_cmd
                    && (I_CMD.addr == SMR_ADDR_INFO);
   assign cal_done = (cal_state == SMR_C_BUSY) && (cal_cnt == '0);

   // Pin sense to result; 11 says only that a resistor is seen
   assign st_result = (I_PIN_SENSE == SMR_PIN_CA) ? SMR_ST_CA_FLOAT :
                      (I_PIN_SENSE == SMR_PIN_GND) ? SMR_ST_GND :
                      SMR_ST_OK;

   // Information word; reserved bits and invalid-data bit are zero
   assign info_word = {3'h0, selftest, 1'b0, DEVICE_IS_NVM,
                       auto_init_flag};
   // Write-only and unmapped registers read as zero
   assign rd_word = rd_info ? info_word : SMR_ZERO8;

   // Recovery cycles: codes 1..6 give 3..8, reserved give default
   assign wr_cycles = ((feat.recovery_clock_count >= SMR_WR_MIN)
                       && (feat.recovery_clock_count <= SMR_WR_MAX))
                      ? {1'b0, feat.recovery_clock_count} + SMR_WR_BASE
                      : SMR_WR_DEF;

   assign next_beats = beats_of(feat.burst_length);
   assign next_mask = 4'(next_beats - 5'h01);
   assign burst_last = (b_state == SMR_B_RUN) && (beat == beats - 5'h01);

   // Feature register; reserved codes are the controller's to avoid
   always_ff @(posedge I_CLK) begin
      if (I_SRST) begin
         feat <= smr_feat_t'(SMR_FEAT_RESET);
      end else if (wr_feat) begin
         feat <= smr_feat_t'(I_CMD.op);
      end
   end

   // Self-initialisation countdown after reset
   always_ff @(posedge I_CLK) begin
      if (I_SRST) begin
         init_cnt <= INIT_W'(AUTO_INIT_CYCLES);
         auto_init_flag <= 1'b1; // In progress
      end else if (init_cnt != '0) begin
         init_cnt <= init_cnt - INIT_W'(1);
      end else begin
         auto_init_flag <= 1'b0; // Complete
      end
   end

   // Calibration sequencer and self-test result capture
   always_ff @(posedge I_CLK) begin
      if (I_SRST) begin
         cal_state <= SMR_C_IDLE;
         cal_cnt <= '0;
         selftest <= SMR_ST_NONE;
      end else begin
         unique case (cal_state)
            // Wait for an accepted calibration command
            SMR_C_IDLE: begin
               if (wr_cal) begin
                  cal_state <= SMR_C_BUSY;
                  cal_cnt <= CAL_W'(CALIB_CYCLES - 1);
               end
            end
            // Count down, then record the result
            SMR_C_BUSY: begin
               if (cal_done) begin
                  cal_state <= SMR_C_IDLE;
                  if (SELFTEST_SUPPORTED) begin
                     selftest <= st_result;
                  end
               end else begin
                  cal_cnt <= cal_cnt - CAL_W'(1);
               end
            end
         endcase
      end
   end

   // Read answer, one cycle after the read command
   always_ff @(posedge I_CLK) begin
      if (I_SRST) begin
         O_RD_VALID <= 1'b0;
         O_RD_DATA <= SMR_ZERO8;
      end else begin
         O_RD_VALID <= I_CMD.mode_reg_read_cmd;
         O_RD_DATA <= I_CMD.mode_reg_read_cmd ? rd_word : SMR_ZERO8;
      end
   end

   // Burst engine; a new start restarts at once
   always_ff @(posedge I_CLK) begin
      if (I_SRST) begin
         b_state <= SMR_B_IDLE;
         beat <= '0;
         beats <= SMR_BEATS4;
         b_start <= '0;
         b_intl <= 1'b0;
         b_nowrap <= 1'b0;
         b_mask <= '0;
      end else if (I_BURST_START) begin
         b_state <= SMR_B_RUN;
         beat <= '0;
         beats <= next_beats;
         b_start <= I_BURST_COL;
         // Interleave only defined for 8 beats; 4 beats equal both ways
         b_intl <= feat.burst_type
                   && (feat.burst_length == SMR_BL8);
         // No wrap only honoured for 4 beats
         b_nowrap <= feat.wrap_control
                     && (next_beats == SMR_BEATS4);
         b_mask <= next_mask;
      end else begin
         unique case (b_state)
            SMR_B_IDLE: begin
               beat <= '0;
            end
            SMR_B_RUN: begin
               if (burst_last) begin
                  b_state <= SMR_B_IDLE;
               end
               beat <= burst_last ? 5'h00 : beat + 5'h01;
            end
         endcase
      end
   end

   // Burst column outputs registered one cycle behind the engine
   always_ff @(posedge I_CLK) begin
      if (I_SRST) begin
         O_BURST_VALID <= 1'b0;
         O_BURST_COL <= '0;
         O_BURST_LAST <= 1'b0;
      end else begin
         O_BURST_VALID <= (b_state == SMR_B_RUN) && !I_BURST_START;
         O_BURST_LAST <= burst_last && !I_BURST_START;
         O_BURST_COL <= burst_col(b_start, beat[3:0], b_mask, b_intl,
                                  b_nowrap);
      end
   end

   // Status outputs
   assign O_AUTO_INIT_BUSY = auto_init_flag;
   assign O_USE_FACTORY_TRIM = st_fault;
   assign O_CALIB_BUSY = (cal_state == SMR_C_BUSY);
   assign O_RECOVERY_CYCLES = wr_cycles;

endmodule // smr_mode_regs
`default_nettype wire

//--- rtl/smr_pkg.sv
// Package: register map, field layout and encodings of the mode register bank
package smr_pkg;
   // Register addresses on the mode register command
   localparam logic [7:0] SMR_ADDR_INFO = 8'h00; // device_info_status
   localparam logic [7:0] SMR_ADDR_FEAT = 8'h01; // burst_feature_config
   localparam logic [7:0] SMR_ADDR_CAL = 8'h0A; // calibration command

   // Field positions in device_info_status
   localparam int SMR_INFO_AUTO_INIT = 0; // auto_init_flag
   localparam int SMR_INFO_KIND = 1; // device_kind
   localparam int SMR_INFO_INVALID = 2; // invalid_data_info
   localparam int SMR_INFO_ST_LO = 3; // calib_resistor_selftest low bit

   // Self-test result codes
   localparam logic [1:0] SMR_ST_NONE = 2'h0; // Self-test not supported
   localparam logic [1:0] SMR_ST_CA_FLOAT = 2'h1; // Tied to ca_supply/floating
   localparam logic [1:0] SMR_ST_GND = 2'h2; // Shorted to ground
   localparam logic [1:0] SMR_ST_OK = 2'h3; // Resistor detected

   // Pin sense codes seen by the self-test comparator
   localparam logic [1:0] SMR_PIN_RES = 2'h0; // Resistor present
   localparam logic [1:0] SMR_PIN_CA = 2'h1; // Tied to ca_supply or floating
   localparam logic [1:0] SMR_PIN_GND = 2'h2; // Shorted to ground

   // Burst length codes
   localparam logic [2:0] SMR_BL4 = 3'h2;
   localparam logic [2:0] SMR_BL8 = 3'h3;
   localparam logic [2:0] SMR_BL16 = 3'h4;
   // Recovery count codes and their cycle base
   localparam logic [2:0] SMR_WR_MIN = 3'h1; // 3 cycles
   localparam logic [2:0] SMR_WR_MAX = 3'h6; // 8 cycles
   localparam logic [3:0] SMR_WR_BASE = 4'h2; // cycles = code + base
   localparam logic [3:0] SMR_WR_DEF = 4'h3; // Cycles for reserved codes

   // Beat counts
   localparam logic [4:0] SMR_BEATS4 = 5'h04;
   localparam logic [4:0] SMR_BEATS8 = 5'h08;
   localparam logic [4:0] SMR_BEATS16 = 5'h10;

   // Reset value of burst_feature_config: 4 beats, seq, wrap, 3 cycles
   localparam logic [7:0] SMR_FEAT_RESET = 8'h22;
   localparam logic [7:0] SMR_ZERO8 = 8'h00;

   // Fields of burst_feature_config, msb first
   typedef struct packed {
      logic [2:0] recovery_clock_count; // Bits 7:5
      logic wrap_control; // Bit 4, 1 = no wrap
      logic burst_type; // Bit 3, 1 = interleaved
      logic [2:0] burst_length; // Bits 2:0
   } smr_feat_t;

   // Mode register command from the controller
   typedef struct packed {
      logic mode_reg_write_cmd; // One-cycle write strobe
      logic mode_reg_read_cmd; // One-cycle read strobe
      logic [7:0] addr; // Register address
      logic [7:0] op; // Write data
   } smr_cmd_t;

   // Burst engine states
   typedef enum logic [1:0] {
      SMR_B_IDLE = 2'b01,
      SMR_B_RUN = 2'b10
   } smr_bstate_t;

   // Calibration states
   typedef enum logic [1:0] {
      SMR_C_IDLE = 2'b01,
      SMR_C_BUSY = 2'b10
   } smr_cstate_t;
endpackage

//--- verif/sdram_mode_reg_burst_order_bench.sv
// Bench: register access, calibration self-test and burst ordering
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin \
   compares++; \
   if ((g) !== (e)) begin \
      n_fail++; \
      $display("unexpected %s exp %h got %h", nm, e, g); \
   end \
end
module sdram_mode_reg_burst_order_bench
   import smr_pkg::*;
;
   localparam int CW = 10;
   localparam int CAL_N = 3; // Calibration length used in the bench
   logic clk = 0, srst = 1, bstart = 0, rv, aib, trim, cbusy, bv, blast;
   logic [1:0] pin = SMR_PIN_RES;
   logic [CW-1:0] bcol = '0, col;
   logic [7:0] rd;
   logic [3:0] rec;
   smr_cmd_t cmd;
   int n_fail = 0, compares = 0;
   logic [1:0] stx [4] = '{2'h3, 2'h1, 2'h2, 2'h3};
   logic [7:0] ops [5] = '{8'h22, 8'h23, 8'h2B, 8'h32, 8'h24};
   logic [CW-1:0] cols [5] = '{10'h1F7, 10'h006, 10'h006, 10'h1F6, 10'h002};
   always #20 clk = ~clk;
   smr_ctrl_model i_ctl (.i_clk(clk), .o_cmd(cmd));
   smr_mode_regs #(.COL_W(CW), .AUTO_INIT_CYCLES(5), .CALIB_CYCLES(CAL_N)) i_dut (
      .I_CLK(clk), .I_SRST(srst), .I_CMD(cmd), .I_PIN_SENSE(pin),
      .I_BURST_START(bstart), .I_BURST_COL(bcol), .O_RD_VALID(rv),
      .O_RD_DATA(rd), .O_AUTO_INIT_BUSY(aib), .O_USE_FACTORY_TRIM(trim),
      .O_CALIB_BUSY(cbusy), .O_RECOVERY_CYCLES(rec), .O_BURST_VALID(bv),
      .O_BURST_COL(col), .O_BURST_LAST(blast));
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic report_and_stop;
      $display("counts: %0d compares, %0d mismatches", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic reset_dut;
      srst = 1;
      tick(5);
      srst = 0;
   endtask
   // Bounded wait for init and calibration to finish
   task automatic wait_quiet;
      int k;
      for (k = 0; k < 50 && (cbusy || aib); k++) tick(1);
      if (cbusy !== 1'b0 || aib !== 1'b0) begin
         $display("unexpected quiet exp 0 got %b", cbusy | aib);
         n_fail++;
         report_and_stop();
      end
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      i_ctl.issue(1'b0, a, 8'h00);
      `CHK("read data", {1'b1, e}, {rv, rd})
   endtask
   // Calibrate; eb says whether the command must be accepted
   task automatic cal(input logic [1:0] p, input logic eb);
      int k;
      pin = p;
      i_ctl.issue(1'b1, SMR_ADDR_CAL, 8'h00);
      `CHK("calib busy", eb, cbusy)
      for (k = 0; k < 10 && cbusy; k++) tick(1);
      `CHK("calib cycles", eb ? CAL_N : 0, k)
      wait_quiet();
   endtask
   // Program features, start a burst, compare every beat
   task automatic burst(input logic [7:0] op, input logic [CW-1:0] sc);
      int n, i;
      logic [CW-1:0] s, m, e;
      i_ctl.issue(1'b1, SMR_ADDR_FEAT, op);
      n = op[2:0] == SMR_BL8 ? 8 : op[2:0] == SMR_BL16 ? 16 : 4;
      m = CW'(n - 1);
      s = {sc[CW-1:1], 1'b0};
      bcol = sc;
      bstart = 1;
      tick(1);
      bstart = 0;
      tick(1);
      for (i = 0; i < n; i++) begin
         if (op[4] && n == 4) e = s + CW'(i);
         else if (op[3] && n == 8) e = (s & ~m) | ((s ^ CW'(i)) & m);
         else e = (s & ~m) | ((s + CW'(i)) & m);
         `CHK("beat", {1'b1, i == n - 1, e}, {bv, blast, col})
         tick(1);
      end
      `CHK("burst end", 1'b0, bv)
   endtask
   initial begin
      int c;
      reset_dut();
      `CHK("init busy", 1'b1, aib)
      `CHK("recovery", 4'h3, rec)
      rd_chk(SMR_ADDR_INFO, 8'h01);
      wait_quiet();
      rd_chk(SMR_ADDR_INFO, 8'h00);
      rd_chk(SMR_ADDR_FEAT, 8'h00);
      i_ctl.issue(1'b1, SMR_ADDR_INFO, 8'hFF);
      `CHK("recovery", 4'h3, rec)
      rd_chk(SMR_ADDR_INFO, 8'h00);
      for (c = 1; c <= 6; c++) begin
         i_ctl.issue(1'b1, SMR_ADDR_FEAT, {c[2:0], 5'h02});
         `CHK("recovery", 4'(c + 2), rec)
      end
      i_ctl.issue(1'b1, SMR_ADDR_FEAT, {i_ctl.rec_code(210), 5'h02});
      `CHK("recovery", 4'h6, rec)
      $display("test registers done");
      for (c = 0; c < 5; c++) burst(ops[c], cols[c]);
      $display("test bursts done");
      for (c = 0; c < 4; c++) begin
         reset_dut();
         cal(2'(c), 1'b1);
         rd_chk(SMR_ADDR_INFO, {3'h0, stx[c], 3'h0});
         `CHK("trim", stx[c] inside {2'h1, 2'h2}, trim)
         cal(SMR_PIN_RES, !(stx[c] inside {2'h1, 2'h2}));
         rd_chk(SMR_ADDR_INFO, {3'h0, stx[c], 3'h0});
      end
      $display("test calibration done");
      report_and_stop();
   end
endmodule // sdram_mode_reg_burst_order_bench
`default_nettype wire

//--- verif/smr_ctrl_model.sv
// Controller model: issues mode register read and write commands
`timescale 1ns/1ps
`default_nettype none
module smr_ctrl_model
   import smr_pkg::*;
(
   input wire logic i_clk,
   output var smr_cmd_t o_cmd
);
   // Idle bus at start
   initial o_cmd = '0;
   // Idle edge first, so back-to-back calls never drive twice at once
   // One-cycle command, then address and data turned over
   task automatic issue(input logic w, input logic [7:0] a,
                        input logic [7:0] d);
      @(posedge i_clk);
      #1 o_cmd <= '{w, !w, a, d};
      @(posedge i_clk);
      #1 o_cmd <= '{1'b0, 1'b0, ~a, ~d};
   endtask
   // Recovery code from recovery time, whole cycles rounded up
   function automatic logic [2:0] rec_code(input int twr_ns);
      int n;
      n = (twr_ns + 39) / 40;
      return (n < 3) ? 3'h1 : 3'(n - 2);
   endfunction
endmodule // smr_ctrl_model
`default_nettype wire

//--- verif/smr_mode_regs_chk.sv
// Checker: port timing relations of the mode register bank
`timescale 1ns/1ps
`default_nettype none
module smr_mode_regs_chk
   import smr_pkg::*;
#(
   parameter int COL_W = 10 // Column address width
) (
   input wire logic I_CLK,
   input wire logic I_SRST,
   input wire smr_cmd_t I_CMD,
   input wire logic [1:0] I_PIN_SENSE,
   input wire logic I_BURST_START,
   input wire logic [COL_W-1:0] I_BURST_COL,
   input wire logic O_RD_VALID,
   input wire logic [7:0] O_RD_DATA,
   input wire logic O_AUTO_INIT_BUSY,
   input wire logic O_USE_FACTORY_TRIM,
   input wire logic O_CALIB_BUSY,
   input wire logic [3:0] O_RECOVERY_CYCLES,
   input wire logic O_BURST_VALID,
   input wire logic [COL_W-1:0] O_BURST_COL,
   input wire logic O_BURST_LAST
);
   // One clock domain, reset disables all checks
   default clocking cb @(posedge I_CLK);
   endclocking
   default disable iff (I_SRST);
   // Read answer one cycle after the command
   property p_rd_lat;
      I_CMD.mode_reg_read_cmd |=> O_RD_VALID;
   endproperty
   a_rd_lat: assert property (p_rd_lat) else $error("read late");
   // Unused and unsupported bits read zero
   property p_rsvd;
      O_RD_VALID |-> O_RD_DATA[7:5] == 3'h0 && !O_RD_DATA[2];
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved set");
   // Bit 0 mirrors the init flag at the command edge
   property p_init;
      O_RD_VALID && $past(I_CMD.addr) == SMR_ADDR_INFO
         |-> O_RD_DATA[0] == $past(O_AUTO_INIT_BUSY);
   endproperty
   a_init: assert property (p_init) else $error("init bit");
   // Fault codes and factory trim agree
   property p_trim;
      O_RD_VALID && $past(I_CMD.addr) == SMR_ADDR_INFO
         |-> (O_RD_DATA[4:3] inside {2'h1, 2'h2}) == $past(O_USE_FACTORY_TRIM);
   endproperty
   a_trim: assert property (p_trim) else $error("trim mismatch");
   // First beat two cycles on, even column
   property p_first;
      I_BURST_START |-> ##2 O_BURST_VALID && !O_BURST_COL[0]
         && O_BURST_COL[COL_W-1:1] == $past(I_BURST_COL[COL_W-1:1], 2);
   endproperty
   a_first: assert property (p_first) else $error("first beat");
   // Last beat ends the burst
   property p_last;
      O_BURST_LAST |-> O_BURST_VALID ##1
         (!O_BURST_VALID || $past(I_BURST_START, 2));
   endproperty
   a_last: assert property (p_last) else $error("last beat");
   // Calibration only starts from its write
   property p_cal;
      $rose(O_CALIB_BUSY) |-> $past(I_CMD.mode_reg_write_cmd)
         && $past(I_CMD.addr) == SMR_ADDR_CAL;
   endproperty
   a_cal: assert property (p_cal) else $error("cal start");
   // Self-test result moves only as calibration ends
   property p_trim_chg;
      $changed(O_USE_FACTORY_TRIM) |-> $fell(O_CALIB_BUSY);
   endproperty
   a_trim_chg: assert property (p_trim_chg) else $error("trim moved");
   // Recovery count stays within its legal span
   property p_rec;
      O_RECOVERY_CYCLES inside {[4'h3:4'h8]};
   endproperty
   a_rec: assert property (p_rec) else $error("recovery span");
   // Pin tied to supply leaves a fault code after calibration
   property p_pin_ca;
      $fell(O_CALIB_BUSY) && $past(I_PIN_SENSE) == SMR_PIN_CA
         |-> O_USE_FACTORY_TRIM;
   endproperty
   a_pin_ca: assert property (p_pin_ca) else $error("pin ca code");
   // Main scenarios reached
   c_last: cover property (O_BURST_LAST);
   c_fault: cover property (O_USE_FACTORY_TRIM);
   c_cal: cover property ($fell(O_CALIB_BUSY));
endmodule // smr_mode_regs_chk

bind smr_mode_regs smr_mode_regs_chk #(.COL_W(COL_W)) i_chk (
   .I_CLK(I_CLK), .I_SRST(I_SRST), .I_CMD(I_CMD),
   .I_PIN_SENSE(I_PIN_SENSE), .I_BURST_START(I_BURST_START),
   .I_BURST_COL(I_BURST_COL), .O_RD_VALID(O_RD_VALID),
   .O_RD_DATA(O_RD_DATA), .O_AUTO_INIT_BUSY(O_AUTO_INIT_BUSY),
   .O_USE_FACTORY_TRIM(O_USE_FACTORY_TRIM), .O_CALIB_BUSY(O_CALIB_BUSY),
   .O_RECOVERY_CYCLES(O_RECOVERY_CYCLES), .O_BURST_VALID(O_BURST_VALID),
   .O_BURST_COL(O_BURST_COL), .O_BURST_LAST(O_BURST_LAST));
`default_nettype wire
